// ---- verilog/slc_pkg.sv ----
// Purpose: shared constants and types of the stack limit checker
// Assumes: 16-bit data space, word-aligned stack, 23-bit program counter
// Notes: the word step, stack pointer reset value, stack floor and pc upper field position live here
`default_nettype none

package slc_pkg;

	// ------------------------------------------------------------
	// widths and fixed values
	// ------------------------------------------------------------
	localparam int unsigned SLC_AW = 16;
	localparam int unsigned SLC_PC_W = 23;
	localparam int unsigned SLC_SRL_W = 8;
	localparam int unsigned SLC_PC_HI_LSB = 16;
	localparam logic [15:0] SLC_SP_FLOOR = 16'h0800;
	localparam logic [15:0] SLC_SP_RESET = 16'h0800;
	localparam logic [15:0] SLC_WORD_STEP = 16'h0002;
	localparam logic [7:0] SLC_CALL_UPPER = 8'h00;

	// ------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SLC_K_PUSH = 3'h0,
		SLC_K_POP = 3'h1,
		SLC_K_CALL = 3'h2,
		SLC_K_EXC = 3'h3,
		SLC_K_ACCESS = 3'h4
	} slc_kind_t;

	typedef enum logic [0:0] {
		SLC_S_IDLE = 1'b0,
		SLC_S_HIGH = 1'b1
	} slc_state_t;

	typedef enum logic [1:0] {
		SLC_SEG_GENERAL = 2'h0,
		SLC_SEG_BOOT = 2'h1,
		SLC_SEG_SECURE = 2'h2
	} slc_code_seg_t;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		slc_kind_t kind;
		logic [15:0] wdata;
		logic [15:0] ea;
		logic [SLC_PC_W-1:0] pc;
		logic [SLC_SRL_W-1:0] status_low_byte;
	} slc_op_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} slc_mem_t;

	typedef struct packed {
		logic enable;
		logic [15:0] base;
		logic [15:0] last;
	} slc_seg_t;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		slc_code_seg_t code_seg;
	} slc_data_req_t;

endpackage

`default_nettype wire

// ---- verilog/slc_ram_guard.sv ----
// Purpose: secure data ram segment guard
// Assumes: core reports which flash segment the running code sits in
// Notes: deny is combinational, in the cycle of the request
`default_nettype none

module slc_ram_guard import slc_pkg::*; (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire slc_data_req_t i_req,
	input wire slc_seg_t i_boot_seg,
	input wire slc_seg_t i_secure_seg,
	output logic o_deny
);

	function automatic logic slc_in_seg(input logic [15:0] addr, input slc_seg_t seg);
		slc_in_seg = seg.enable && (addr >= seg.base) && (addr <= seg.last);
	endfunction

	logic boot_hit;
	logic secure_hit;

	// ------------------------------------------------------------
	// access check
	// ------------------------------------------------------------
	always_comb begin
		boot_hit = i_req.valid && slc_in_seg(i_req.addr, i_boot_seg) &&
			(i_req.code_seg != SLC_SEG_BOOT);
		secure_hit = i_req.valid && slc_in_seg(i_req.addr, i_secure_seg) &&
			(i_req.code_seg != SLC_SEG_SECURE);
		o_deny = boot_hit || secure_hit;
	end

	chk_boot_seg_deny: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.valid && i_boot_seg.enable && i_req.addr >= i_boot_seg.base &&
		i_req.addr <= i_boot_seg.last) |-> (o_deny == (i_req.code_seg != SLC_SEG_BOOT)))
		else $error("boot secure ram segment access decision wrong");

	chk_secure_seg_deny: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(i_req.valid && i_secure_seg.enable &&
		i_req.addr >= i_secure_seg.base && i_req.addr <= i_secure_seg.last &&
		!(i_boot_seg.enable && i_req.addr >= i_boot_seg.base &&
		i_req.addr <= i_boot_seg.last))
		|-> (o_deny == (i_req.code_seg != SLC_SEG_SECURE)))
		else $error("secure segment ram access decision wrong");

endmodule // slc_ram_guard

`default_nettype wire

// ---- verilog/slc_stack_limit_checker.sv ----
// Purpose: software stack pointer, stack limit check and data ram guard
// Assumes: core raises one stack request per cycle while o_ready is high
// Notes: limit register has no reset; memory requests leave one cycle late
//
// Functional notes
// - the stack pointer always holds the next free word and the stack grows upward.
// - a pop decrements the pointer then reads, a push writes then increments.
// - a call pushes the program counter with its upper byte top bit cleared.
// - exception entry pushes an upper word of status low byte joined to the counter upper byte.
// - bit 0 of the stack limit register reads zero once the register has been written.
// - the stack limit register takes no value at reset.
// - every address formed from the stack pointer is compared with the limit.
// - a push with pointer equal to the limit passes, the next push traps.
// - a stack address below 0x0800 raises an underflow trap.
// - an enabled boot secure ram segment admits only boot segment code.
// - an enabled secure segment ram admits only secure segment code.
`default_nettype none

module slc_stack_limit_checker import slc_pkg::*; #(
	parameter logic [15:0] P_SP_FLOOR = SLC_SP_FLOOR
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire slc_op_t i_op,
	input wire logic i_sp_wr,
	input wire logic [15:0] i_sp_wdata,
	input wire logic i_lim_wr,
	input wire logic [15:0] i_lim_wdata,
	input wire slc_data_req_t i_data_req,
	input wire slc_seg_t i_boot_seg,
	input wire slc_seg_t i_secure_seg,
	output logic o_ready,
	output logic o_trap,
	output logic o_overflow,
	output logic o_underflow,
	output logic [15:0] o_stack_pointer_register,
	output logic [15:0] o_stack_limit_register,
	output slc_mem_t o_mem,
	output logic o_data_deny
);

	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	if (P_SP_FLOOR[0] != 1'b0) begin : g_bad_floor
		$error("stack floor must be word aligned");
	end

	function automatic logic [15:0] slc_word(input logic [15:0] value);
		slc_word = {value[15:1], 1'b0};
	endfunction

	slc_state_t state_q, state_d;
	logic [15:0] sp_q, sp_d;
	logic [15:0] lim_q, lim_d;
	logic [15:0] hi_q, hi_d;
	slc_mem_t mem_q, mem_d;
	logic active;
	logic [15:0] ea;
	logic [6:0] pc_hi;

	// ------------------------------------------------------------
	// effective address and trap detection
	// ------------------------------------------------------------
	always_comb begin
		active = (state_q == SLC_S_HIGH) || i_op.valid;
		ea = sp_q;
		if (state_q == SLC_S_IDLE) begin
			case (i_op.kind)
				SLC_K_POP: ea = sp_q - SLC_WORD_STEP;
				SLC_K_ACCESS: ea = i_op.ea;
				default: ea = sp_q;
			endcase
		end
		o_overflow = active && (ea > lim_q);
		o_underflow = active && (ea < P_SP_FLOOR);
		o_trap = o_overflow || o_underflow;
		o_ready = (state_q == SLC_S_IDLE);
		pc_hi = i_op.pc[SLC_PC_W-1:SLC_PC_HI_LSB];
	end

	// ------------------------------------------------------------
	// stack pointer, limit and memory request
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		sp_d = sp_q;
		hi_d = hi_q;
		mem_d = '0;
		lim_d = lim_q;
		if (i_lim_wr) begin
			lim_d = slc_word(i_lim_wdata);
		end
		case (state_q)
			SLC_S_HIGH: begin
				state_d = SLC_S_IDLE;
				if (!o_trap) begin
					mem_d = '{valid: 1'b1, write: 1'b1, addr: sp_q, wdata: hi_q};
					sp_d = sp_q + SLC_WORD_STEP;
				end
			end
			default: begin
				if (i_op.valid && !o_trap) begin
					case (i_op.kind)
						SLC_K_PUSH: begin
							mem_d = '{valid: 1'b1, write: 1'b1, addr: sp_q, wdata: i_op.wdata};
							sp_d = sp_q + SLC_WORD_STEP;
						end
						SLC_K_POP: begin
							mem_d = '{valid: 1'b1, write: 1'b0, addr: ea, wdata: 16'h0000};
							sp_d = ea;
						end
						SLC_K_CALL: begin
							mem_d = '{valid: 1'b1, write: 1'b1, addr: sp_q,
								wdata: i_op.pc[15:0]};
							sp_d = sp_q + SLC_WORD_STEP;
							hi_d = {SLC_CALL_UPPER, 1'b0, pc_hi};
							state_d = SLC_S_HIGH;
						end
						SLC_K_EXC: begin
							mem_d = '{valid: 1'b1, write: 1'b1, addr: sp_q,
								wdata: i_op.pc[15:0]};
							sp_d = sp_q + SLC_WORD_STEP;
							hi_d = {i_op.status_low_byte, 1'b0, pc_hi};
							state_d = SLC_S_HIGH;
						end
						default: begin
						end
					endcase
				end
			end
		endcase
		if (i_sp_wr) begin
			sp_d = slc_word(i_sp_wdata);
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_resetn) begin
			state_q <= SLC_S_IDLE;
			sp_q <= SLC_SP_RESET;
			hi_q <= 16'h0000;
			mem_q <= '0;
		end else begin
			state_q <= state_d;
			sp_q <= sp_d;
			hi_q <= hi_d;
			mem_q <= mem_d;
		end
	end

	// limit is left out of reset on purpose; software must load it
	always_ff @(posedge i_clock) begin
		lim_q <= lim_d;
	end

	assign o_stack_pointer_register = sp_q;
	assign o_stack_limit_register = lim_q;
	assign o_mem = mem_q;

	// ------------------------------------------------------------
	// secure ram guard
	// ------------------------------------------------------------
	slc_ram_guard u_guard (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_req(i_data_req),
		.i_boot_seg(i_boot_seg),
		.i_secure_seg(i_secure_seg),
		.o_deny(o_data_deny)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_push_write_inc: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_ready && i_op.valid && i_op.kind == SLC_K_PUSH && !o_trap && !i_sp_wr)
		|=> (o_mem.valid && o_mem.write && o_mem.addr == $past(sp_q) &&
		o_stack_pointer_register == $past(sp_q) + SLC_WORD_STEP))
		else $error("push did not write at pointer then increment");

	chk_pop_dec_read: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_ready && i_op.valid && i_op.kind == SLC_K_POP && !o_trap && !i_sp_wr)
		|=> (o_mem.valid && !o_mem.write && o_mem.addr == $past(sp_q) - SLC_WORD_STEP &&
		o_stack_pointer_register == o_mem.addr))
		else $error("pop did not decrement then read");

	chk_next_free_word: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_mem.valid && o_mem.write && !$past(i_sp_wr))
		|-> (o_stack_pointer_register == o_mem.addr + SLC_WORD_STEP))
		else $error("pointer does not sit on the next free word");

	chk_call_upper_clear: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_ready && i_op.valid && i_op.kind == SLC_K_CALL && !o_trap)
		|-> ##2 (!o_mem.valid || o_mem.wdata[15:7] == 9'h000))
		else $error("call upper word not zero extended");

	chk_exc_status_join: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_ready && i_op.valid && i_op.kind == SLC_K_EXC && !o_trap)
		|-> ##2 (!o_mem.valid || (o_mem.wdata[15:8] == $past(i_op.status_low_byte, 2) &&
		o_mem.wdata[6:0] == $past(pc_hi, 2))))
		else $error("exception upper word not status byte joined to counter");

	chk_limit_lsb_zero: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$past(i_lim_wr) |-> (o_stack_limit_register == slc_word($past(i_lim_wdata))))
		else $error("limit register low bit not forced clear");

	chk_overflow_trap: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_ready && i_op.valid && i_op.kind == SLC_K_ACCESS && i_op.ea > lim_q)
		|-> (o_trap && o_overflow) ##1 !o_mem.valid)
		else $error("address past limit did not trap");

	chk_equal_no_trap: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_ready && i_op.valid && i_op.kind == SLC_K_PUSH && sp_q == lim_q &&
		sp_q >= P_SP_FLOOR && !i_sp_wr && !i_lim_wr)
		|-> !o_trap)
		else $error("push at limit trapped");

	chk_beyond_limit: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_ready && i_op.valid && i_op.kind == SLC_K_PUSH && sp_q == lim_q &&
		sp_q >= P_SP_FLOOR && !i_sp_wr && !i_lim_wr)
		|=> ((o_ready && i_op.valid && i_op.kind == SLC_K_PUSH) |-> o_overflow))
		else $error("push beyond limit did not trap");

	chk_underflow_trap: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(active && ea < P_SP_FLOOR) |-> (o_underflow && o_trap) ##1 !o_mem.valid)
		else $error("address below floor did not trap");

	chk_trap_one_cycle: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(o_trap && !i_op.valid && state_q == SLC_S_HIGH) |=> !o_trap)
		else $error("trap held beyond its address cycle");

endmodule // slc_stack_limit_checker

`default_nettype wire

// ---- testbench/slc_core_model.sv ----
// Purpose: core-side data memory answering the checker's stack requests
// Assumes: read data is returned one cycle after the request; address bits 8:1 pick the word
// Notes: between reads the data lines toggle, so stale data never looks valid
`default_nettype none

module slc_core_model import slc_pkg::*; (
	input wire logic i_clock,
	input wire slc_mem_t i_mem,
	output logic [15:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem_q [0:255];
	logic [15:0] rdata_q = 16'h5A5A;

	always @(posedge i_clock) begin
		rdata_q <= ~rdata_q;
		if (i_mem.valid && i_mem.write) begin
			mem_q[i_mem.addr[8:1]] <= i_mem.wdata;
		end
		if (i_mem.valid && !i_mem.write) begin
			rdata_q <= mem_q[i_mem.addr[8:1]];
		end
	end

	assign o_rdata = rdata_q;
endmodule // slc_core_model
`default_nettype wire

// ---- testbench/stack_limit_checker_tb.sv ----
// Purpose: self-checking bench of the stack limit checker
// Assumes: core model answers pops one cycle after the memory request
// Notes: the limit is written before any stack request
`default_nettype none

module stack_limit_checker_tb import slc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	slc_op_t i_op = '0;
	logic i_sp_wr = 1'b0;
	logic i_lim_wr = 1'b0;
	logic [15:0] i_sp_wdata = 16'h0;
	logic [15:0] i_lim_wdata = 16'h0;
	slc_data_req_t i_data_req = '0;
	slc_seg_t i_boot_seg = '0;
	slc_seg_t i_secure_seg = '0;
	logic o_ready, o_trap, o_overflow, o_underflow, o_data_deny;
	logic [15:0] o_stack_pointer_register, o_stack_limit_register, rdata;
	slc_mem_t o_mem;
	int errors = 0;
	int n_compared = 0;

	slc_stack_limit_checker dut (.i_clock, .i_resetn, .i_op, .i_sp_wr, .i_sp_wdata,
		.i_lim_wr, .i_lim_wdata, .i_data_req, .i_boot_seg, .i_secure_seg, .o_ready,
		.o_trap, .o_overflow, .o_underflow, .o_stack_pointer_register,
		.o_stack_limit_register, .o_mem, .o_data_deny);
	slc_core_model core (.i_clock, .i_mem(o_mem), .o_rdata(rdata));

	initial begin
		forever #12.5 i_clock = ~i_clock;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic lim, input logic [15:0] v);
		i_lim_wr = lim;
		i_sp_wr = !lim;
		i_lim_wdata = v;
		i_sp_wdata = v;
		@(posedge i_clock) #1;
		i_lim_wr = 1'b0;
		i_sp_wr = 1'b0;
		// one quiet edge keeps strobes from toggling twice in one step
		@(posedge i_clock) #1;
	endtask

	// request stays up after return; t is {overflow, underflow}
	task automatic op(input slc_kind_t k, input logic [15:0] d, input logic [1:0] t);
		i_op = '{valid: 1'b1, kind: k, wdata: d, ea: d, pc: 23'h7F1234, status_low_byte: 8'hA5};
		#2;
		chk({o_trap, o_overflow, o_underflow}, {|t, t});
		@(posedge i_clock) #1;
	endtask

	task automatic idle();
		i_op.valid = 1'b0;
		@(posedge i_clock) #1;
	endtask

	task automatic finish_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk(o_stack_pointer_register, 16'h0800);
		chk(o_stack_limit_register, 16'hXXXX);
		chk({o_ready, o_mem}, {1'b1, 34'h0});
		wr(1'b1, 16'h0FFF);
		chk(o_stack_limit_register, 16'h0FFE);
	endtask

	task automatic t_push_pop();
		wr(1'b0, 16'h0900);
		op(SLC_K_PUSH, 16'hBEEF, 2'b00);
		chk(o_mem, {2'b11, 16'h0900, 16'hBEEF});
		op(SLC_K_PUSH, 16'h1234, 2'b00);
		chk(o_stack_pointer_register, 16'h0904);
		op(SLC_K_POP, 16'h0, 2'b00);
		chk(o_mem, {2'b10, 16'h0902, 16'h0});
		idle();
		chk({rdata, o_stack_pointer_register}, {16'h1234, 16'h0902});
	endtask

	task automatic t_frame(input slc_kind_t k, input logic [15:0] up);
		wr(1'b0, 16'h0A00);
		op(k, 16'h0, 2'b00);
		chk({o_ready, o_mem}, {1'b0, 2'b11, 16'h0A00, 16'h1234});
		idle();
		chk(o_mem, {2'b11, 16'h0A02, up});
		chk(o_stack_pointer_register, 16'h0A04);
		op(SLC_K_POP, 16'h0, 2'b00);
		idle();
		chk(rdata, up);
	endtask

	task automatic t_overflow();
		wr(1'b1, 16'h0904);
		wr(1'b0, 16'h0904);
		op(SLC_K_PUSH, 16'h0001, 2'b00);
		op(SLC_K_PUSH, 16'h0002, 2'b10);
		chk({o_mem.valid, o_stack_pointer_register}, {1'b0, 16'h0906});
		idle();
		chk(o_trap, 1'b0);
		// call at the limit: low word passes, upper word traps on its own
		wr(1'b0, 16'h0904);
		op(SLC_K_CALL, 16'h0, 2'b00);
		i_op.valid = 1'b0;
		#2 chk({o_trap, o_overflow, o_underflow}, 3'b110);
		@(posedge i_clock) #1;
		chk({o_mem.valid, o_stack_pointer_register}, {1'b0, 16'h0906});
		chk(o_trap, 1'b0);
		wr(1'b1, 16'h0FFE);
	endtask

	task automatic t_underflow();
		wr(1'b0, 16'h0800);
		op(SLC_K_POP, 16'h0, 2'b01);
		chk(o_mem.valid, 1'b0);
		op(SLC_K_ACCESS, 16'h07FE, 2'b01);
		op(SLC_K_ACCESS, 16'h0800, 2'b00);
		op(SLC_K_ACCESS, 16'h1000, 2'b10);
		idle();
		chk(o_stack_pointer_register, 16'h0800);
	endtask

	task automatic t_guard();
		logic [15:0] a [4] = '{16'h1000, 16'h10FF, 16'h20FF, 16'h2100};
		logic e;
		i_boot_seg = '{1'b1, 16'h1000, 16'h10FF};
		i_secure_seg = '{1'b1, 16'h2000, 16'h20FF};
		for (int s = 0; s < 3; s++) begin
			for (int i = 0; i < 4; i++) begin
				i_data_req = '{1'b1, a[i], slc_code_seg_t'(s)};
				e = (i < 2 && s != 1) || (i == 2 && s != 2);
				#2 chk(o_data_deny, e);
				@(posedge i_clock) #1;
			end
		end
		i_boot_seg.enable = 1'b0;
		i_data_req = '{1'b1, 16'h1000, SLC_SEG_GENERAL};
		#2 chk(o_data_deny, 1'b0);
		i_data_req.valid = 1'b0;
	endtask

	initial begin
		repeat (4) @(posedge i_clock);
		#1 i_resetn = 1'b1;
		@(posedge i_clock) #1;
		t_reset();
		t_push_pop();
		t_frame(SLC_K_CALL, 16'h007F);
		t_frame(SLC_K_EXC, 16'hA57F);
		t_overflow();
		t_underflow();
		t_guard();
		finish_test();
	end

	initial begin
		#10000;
		errors++;
		finish_test();
	end
endmodule // stack_limit_checker_tb
`default_nettype wire
